// ==== logic/buck_bank_consts.vh ====
// Constants for the buck set-point register bank
// Contract
// - Buck A codes 0..29 give 0.700 V plus 25 mV per code.
// - Buck A code 11110 gives 1.8 V, code 11111 gives 3.3 V.
// - Buck A keeps separate Normal, Standby and Sleep 5-bit codes.
// - Buck A fuse default voltage uses the same 5-bit code table.
// - Buck A set points sit at 0x20, 0x21 and 0x22.
// - Buck A mode at 0x23; config at 0x24, aliased at 0x32.
// - Buck B low range: 1.500 V up in 50 mV steps to 1.850 V.
// - Buck B high range: 2.5, 2.8, 2.85, 3.0, 3.1, 3.15, 3.2, 3.3 V.
// - Register writes cannot change buck B range; only the fuse sets it.
// - Buck B keeps three 3-bit set points through the range table.
// - Buck B set points sit at 0x35, 0x36 and 0x37.
// - Buck B mode at 0x38, config at 0x39.
// - Buck C codes give 0.90 V plus 50 mV per code, to 1.65 V.
// - Buck C set points sit at 0x3c, 0x3d and 0x3e.
// - Buck C mode at 0x3f, config at 0x40.
// - Standby targets the Standby set point; leaving returns to Normal.
// - Sleep with retention set targets the Sleep set point.
// - Target changes ramp 25 mV per 2.0 us, or 4.0 us if slow bit set.
`ifndef BUCK_BANK_CONSTS_VH
`define BUCK_BANK_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_A_NORMAL   8'h20
`define ADDR_A_STANDBY  8'h21
`define ADDR_A_SLEEP    8'h22
`define ADDR_A_MODE     8'h23
`define ADDR_A_CONFIG   8'h24
`define ADDR_A_CONFIG2  8'h32
`define ADDR_B_NORMAL   8'h35
`define ADDR_B_STANDBY  8'h36
`define ADDR_B_SLEEP    8'h37
`define ADDR_B_MODE     8'h38
`define ADDR_B_CONFIG   8'h39
`define ADDR_C_NORMAL   8'h3c
`define ADDR_C_STANDBY  8'h3d
`define ADDR_C_SLEEP    8'h3e
`define ADDR_C_MODE     8'h3f
`define ADDR_C_CONFIG   8'h40

// ****************************************
// Fields and reset values
// ****************************************
`define MODE_FIELD_W    6
`define RETAIN_BIT      5
`define RAMP_SLOW_BIT   6
`define MODE_RESET      6'h08
`define MODE_WR_MASK    6'h2f
`define CONF_A_RESET    8'h04
`define CONF_B_RESET    8'h14
`define CONF_C_RESET    8'h24
`define B_RESET_CODE    3'h0
`define C_RESET_CODE    4'h0

// ****************************************
// Voltage decode, millivolts
// ****************************************
`define A_BASE_MV       12'd700
`define A_STEP_MV       12'd25
`define A_LAST_LINEAR   5'h1d
`define A_CODE_1V8      5'h1e
`define A_1V8_MV        12'd1800
`define A_3V3_MV        12'd3300
`define B_LO_BASE_MV    12'd1500
`define B_STEP_MV       12'd50
`define B_HI_0_MV       12'd2500
`define B_HI_1_MV       12'd2800
`define B_HI_2_MV       12'd2850
`define B_HI_3_MV       12'd3000
`define B_HI_4_MV       12'd3100
`define B_HI_5_MV       12'd3150
`define B_HI_6_MV       12'd3200
`define B_HI_7_MV       12'd3300
`define C_BASE_MV       12'd900
`define C_STEP_MV       12'd50

// ****************************************
// Ramp timing
// ****************************************
`define RAMP_STEP_MV    12'd25
`define CLK_PERIOD_NS   100
`define STEP_FAST_NS    2000
`define STEP_SLOW_NS    4000
`define STEP_FAST_CYC   ((`STEP_FAST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_SLOW_CYC   ((`STEP_SLOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FUSE_LOAD_CYC   2'd3

`endif

// ==== logic/buck_setpoint_register_bank.v ====
// Set-point, mode and configuration registers for three buck regulators
`include "buck_bank_consts.vh"

module buck_setpoint_register_bank
(
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Register port from the serial control interface
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_rd,
    output wire [7:0]  reg_rdata,
    // Fuse straps and operating mode pins
    input  wire [4:0]  buck_a_fuse_voltage,
    input  wire        buck_b_high_range_fuse,
    input  wire        standby_req,
    input  wire        sleep_req,
    // Regulator targets and ramped outputs
    output wire [11:0] buck_a_voltage_mv,
    output wire [11:0] buck_b_voltage_mv,
    output wire [11:0] buck_c_voltage_mv,
    output wire [2:0]  buck_on,
    output wire [2:0]  ramp_busy
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    reg  [7:0]  pin_meta_r;
    reg  [7:0]  pin_sync_r;
    wire [4:0]  fuse_a_s   = pin_sync_r[4:0];
    wire        fuse_hi_s  = pin_sync_r[5];
    wire        standby_s  = pin_sync_r[6];
    wire        sleep_s    = pin_sync_r[7];

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_meta_r <= 8'h00;
            pin_sync_r <= 8'h00;
        end
        else
        begin
            pin_meta_r <= {sleep_req, standby_req, buck_b_high_range_fuse,
                           buck_a_fuse_voltage};
            pin_sync_r <= pin_meta_r;
        end
    end

    // ****************************************
    // Fuse capture after reset release
    // ****************************************
    // Fuses are caught once the synchronisers have settled, never under reset
    reg  [1:0]  load_cnt_r;
    reg         loaded_r;
    reg         range_hi_r;
    wire        load_now = !loaded_r && (load_cnt_r == `FUSE_LOAD_CYC);

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            load_cnt_r <= 2'd0;
            loaded_r   <= 1'b0;
            range_hi_r <= 1'b0;
        end
        else if (!loaded_r)
        begin
            load_cnt_r <= load_cnt_r + 2'd1;
            if (load_now)
            begin
                loaded_r   <= 1'b1;
                range_hi_r <= fuse_hi_s;
            end
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    reg  [4:0]  a_normal_r;
    reg  [4:0]  a_standby_r;
    reg  [4:0]  a_sleep_r;
    reg  [2:0]  b_normal_r;
    reg  [2:0]  b_standby_r;
    reg  [2:0]  b_sleep_r;
    reg  [3:0]  c_normal_r;
    reg  [3:0]  c_standby_r;
    reg  [3:0]  c_sleep_r;
    reg  [5:0]  a_mode_r;
    reg  [5:0]  b_mode_r;
    reg  [5:0]  c_mode_r;
    reg  [7:0]  a_conf_r;
    reg  [7:0]  b_conf_r;
    reg  [7:0]  c_conf_r;
    reg  [7:0]  rdata_r;
    reg  [7:0]  rdata_nxt;

    // Bit 4 of a mode register is not built and reads back as zero;
    // the mask keeps it out of the stored value
    wire [5:0]  mode_wdata = reg_wdata[5:0] & `MODE_WR_MASK;

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            a_normal_r  <= 5'h00;
            a_standby_r <= 5'h00;
            a_sleep_r   <= 5'h00;
            b_normal_r  <= `B_RESET_CODE;
            b_standby_r <= `B_RESET_CODE;
            b_sleep_r   <= `B_RESET_CODE;
            c_normal_r  <= `C_RESET_CODE;
            c_standby_r <= `C_RESET_CODE;
            c_sleep_r   <= `C_RESET_CODE;
            a_mode_r    <= `MODE_RESET;
            b_mode_r    <= `MODE_RESET;
            c_mode_r    <= `MODE_RESET;
            a_conf_r    <= `CONF_A_RESET;
            b_conf_r    <= `CONF_B_RESET;
            c_conf_r    <= `CONF_C_RESET;
        end
        else if (load_now)
        begin
            // Fuse code seeds all three buck A fields
            a_normal_r  <= fuse_a_s;
            a_standby_r <= fuse_a_s;
            a_sleep_r   <= fuse_a_s;
        end
        else if (reg_wr && loaded_r)
        begin
            case (reg_addr)
                `ADDR_A_NORMAL:  a_normal_r  <= reg_wdata[4:0];
                `ADDR_A_STANDBY: a_standby_r <= reg_wdata[4:0];
                `ADDR_A_SLEEP:   a_sleep_r   <= reg_wdata[4:0];
                `ADDR_A_MODE:    a_mode_r    <= mode_wdata;
                `ADDR_A_CONFIG:  a_conf_r    <= reg_wdata;
                `ADDR_A_CONFIG2: a_conf_r    <= reg_wdata;
                `ADDR_B_NORMAL:  b_normal_r  <= reg_wdata[2:0];
                `ADDR_B_STANDBY: b_standby_r <= reg_wdata[2:0];
                `ADDR_B_SLEEP:   b_sleep_r   <= reg_wdata[2:0];
                `ADDR_B_MODE:    b_mode_r    <= mode_wdata;
                `ADDR_B_CONFIG:  b_conf_r    <= reg_wdata;
                `ADDR_C_NORMAL:  c_normal_r  <= reg_wdata[3:0];
                `ADDR_C_STANDBY: c_standby_r <= reg_wdata[3:0];
                `ADDR_C_SLEEP:   c_sleep_r   <= reg_wdata[3:0];
                `ADDR_C_MODE:    c_mode_r    <= mode_wdata;
                `ADDR_C_CONFIG:  c_conf_r    <= reg_wdata;
                default:         a_mode_r    <= a_mode_r;
            endcase
        end
    end

    // Unused upper bits and unmapped offsets read as zero
    always @*
    begin
        case (reg_addr)
            `ADDR_A_NORMAL:  rdata_nxt = {3'h0, a_normal_r};
            `ADDR_A_STANDBY: rdata_nxt = {3'h0, a_standby_r};
            `ADDR_A_SLEEP:   rdata_nxt = {3'h0, a_sleep_r};
            `ADDR_A_MODE:    rdata_nxt = {2'h0, a_mode_r};
            `ADDR_A_CONFIG:  rdata_nxt = a_conf_r;
            `ADDR_A_CONFIG2: rdata_nxt = a_conf_r;
            `ADDR_B_NORMAL:  rdata_nxt = {5'h00, b_normal_r};
            `ADDR_B_STANDBY: rdata_nxt = {5'h00, b_standby_r};
            `ADDR_B_SLEEP:   rdata_nxt = {5'h00, b_sleep_r};
            `ADDR_B_MODE:    rdata_nxt = {2'h0, b_mode_r};
            `ADDR_B_CONFIG:  rdata_nxt = b_conf_r;
            `ADDR_C_NORMAL:  rdata_nxt = {4'h0, c_normal_r};
            `ADDR_C_STANDBY: rdata_nxt = {4'h0, c_standby_r};
            `ADDR_C_SLEEP:   rdata_nxt = {4'h0, c_sleep_r};
            `ADDR_C_MODE:    rdata_nxt = {2'h0, c_mode_r};
            `ADDR_C_CONFIG:  rdata_nxt = c_conf_r;
            default:         rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge clk_sys)
    begin
        if (rst)
            rdata_r <= 8'h00;
        else if (reg_rd)
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;

    // ****************************************
    // Code to voltage decode
    // ****************************************
    function [11:0] decode_a;
        input [4:0] code;
        begin
            if (code <= `A_LAST_LINEAR)
                decode_a = `A_BASE_MV + `A_STEP_MV * {7'h00, code};
            else if (code == `A_CODE_1V8)
                decode_a = `A_1V8_MV;
            else
                decode_a = `A_3V3_MV;
        end
    endfunction

    function [11:0] decode_b;
        input [2:0] code;
        input       hi;
        begin
            if (!hi)
                decode_b = `B_LO_BASE_MV + `B_STEP_MV * {9'h000, code};
            else
            begin
                case (code)
                    3'h0:    decode_b = `B_HI_0_MV;
                    3'h1:    decode_b = `B_HI_1_MV;
                    3'h2:    decode_b = `B_HI_2_MV;
                    3'h3:    decode_b = `B_HI_3_MV;
                    3'h4:    decode_b = `B_HI_4_MV;
                    3'h5:    decode_b = `B_HI_5_MV;
                    3'h6:    decode_b = `B_HI_6_MV;
                    default: decode_b = `B_HI_7_MV;
                endcase
            end
        end
    endfunction

    function [11:0] decode_c;
        input [3:0] code;
        begin
            decode_c = `C_BASE_MV + `C_STEP_MV * {8'h00, code};
        end
    endfunction

    // ****************************************
    // Operating mode selection
    // ****************************************
    wire [2:0]  retain = {c_mode_r[`RETAIN_BIT], b_mode_r[`RETAIN_BIT],
                          a_mode_r[`RETAIN_BIT]};
    wire [2:0]  slow   = {c_conf_r[`RAMP_SLOW_BIT], b_conf_r[`RAMP_SLOW_BIT],
                          a_conf_r[`RAMP_SLOW_BIT]};
    wire [4:0]  a_code;
    wire [2:0]  b_code;
    wire [3:0]  c_code;

    // Sleep outranks Standby; a non-retaining regulator in Sleep is switched off
    // At fuse capture the registers take the fuse values on the same edge,
    // so the fuse code and range are decoded directly in that cycle
    wire        range_now = load_now ? fuse_hi_s : range_hi_r;
    assign a_code = load_now               ? fuse_a_s :
                    (sleep_s && retain[0]) ? a_sleep_r :
                    standby_s              ? a_standby_r :
                                             a_normal_r;
    assign b_code = (sleep_s && retain[1]) ? b_sleep_r :
                    standby_s              ? b_standby_r :
                                             b_normal_r;
    assign c_code = (sleep_s && retain[2]) ? c_sleep_r :
                    standby_s              ? c_standby_r :
                                             c_normal_r;

    wire [35:0] target_mv = {decode_c(c_code), decode_b(b_code, range_now),
                             decode_a(a_code)};

    // ****************************************
    // Voltage ramp per regulator
    // ****************************************
    // Ramping never overshoots because every table entry is a multiple of 25 mV
    wire [35:0] cur_mv;
    reg  [2:0]  on_r;

    // Step intervals in clock cycles; the six-bit tick counter limits
    // them to 63 cycles, enough for the slow step at this clock
    localparam integer fast_cycles = `STEP_FAST_CYC;
    localparam integer slow_cycles = `STEP_SLOW_CYC;
    wire [5:0]  fast_cyc = fast_cycles[5:0];
    wire [5:0]  slow_cyc = slow_cycles[5:0];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_ramp
            reg  [11:0] cur_r;
            reg  [5:0]  tick_r;
            reg         busy_r;
            wire [11:0] tgt      = target_mv[gi*12 +: 12];
            wire [5:0]  interval = slow[gi] ? slow_cyc : fast_cyc;

            always @(posedge clk_sys)
            begin
                if (rst)
                begin
                    cur_r  <= 12'h000;
                    tick_r <= 6'h00;
                    busy_r <= 1'b0;
                end
                else if (!loaded_r || load_now)
                begin
                    // Outputs stay at zero until fuse capture, then take the
                    // start-up target directly instead of ramping to it
                    cur_r  <= load_now ? tgt : 12'h000;
                    tick_r <= 6'h00;
                    busy_r <= 1'b0;
                end
                else if (cur_r == tgt)
                begin
                    tick_r <= 6'h00;
                    busy_r <= 1'b0;
                end
                else if (tick_r + 6'h01 >= interval)
                begin
                    tick_r <= 6'h00;
                    busy_r <= 1'b1;
                    if (cur_r < tgt)
                        cur_r <= cur_r + `RAMP_STEP_MV;
                    else
                        cur_r <= cur_r - `RAMP_STEP_MV;
                end
                else
                begin
                    tick_r <= tick_r + 6'h01;
                    busy_r <= 1'b1;
                end
            end

            assign cur_mv[gi*12 +: 12] = cur_r;
            assign ramp_busy[gi]       = busy_r;
        end
    endgenerate

    always @(posedge clk_sys)
    begin
        if (rst)
            on_r <= 3'h0;
        else
            on_r <= {3{loaded_r}} & ~({3{sleep_s}} & ~retain);
    end

    assign buck_a_voltage_mv = cur_mv[11:0];
    assign buck_b_voltage_mv = cur_mv[23:12];
    assign buck_c_voltage_mv = cur_mv[35:24];
    assign buck_on           = on_r;

endmodule // buck_setpoint_register_bank

// ==== tb/buck_bank_props.sv ====
// Assertion checker for the buck set-point register bank
module buck_bank_props
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Fuses and mode pins
    input wire logic [4:0]  buck_a_fuse_voltage,
    input wire logic        buck_b_high_range_fuse,
    input wire logic        standby_req,
    input wire logic        sleep_req,
    // Regulator outputs
    input wire logic [11:0] buck_a_voltage_mv,
    input wire logic [11:0] buck_b_voltage_mv,
    input wire logic [11:0] buck_c_voltage_mv,
    input wire logic [2:0]  buck_on,
    input wire logic [2:0]  ramp_busy
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ****************************************
    // Ramp behaviour
    // ****************************************
    // A zero past value marks the jump to the fuse target, which is not a ramp
    step_a_a: assert property (buck_a_voltage_mv != $past(buck_a_voltage_mv) &&
        $past(buck_a_voltage_mv) != 12'h0 |-> buck_a_voltage_mv == $past(buck_a_voltage_mv) +
        12'd25 || buck_a_voltage_mv + 12'd25 == $past(buck_a_voltage_mv))
        else $error("buck a moved by other than one step");
    step_b_a: assert property (buck_b_voltage_mv != $past(buck_b_voltage_mv) &&
        $past(buck_b_voltage_mv) != 12'h0 |-> buck_b_voltage_mv == $past(buck_b_voltage_mv) +
        12'd25 || buck_b_voltage_mv + 12'd25 == $past(buck_b_voltage_mv))
        else $error("buck b moved by other than one step");
    step_c_a: assert property (buck_c_voltage_mv != $past(buck_c_voltage_mv) &&
        $past(buck_c_voltage_mv) != 12'h0 |-> buck_c_voltage_mv == $past(buck_c_voltage_mv) +
        12'd25 || buck_c_voltage_mv + 12'd25 == $past(buck_c_voltage_mv))
        else $error("buck c moved by other than one step");
    idle_hold_a: assert property (ramp_busy == 3'h0 && $past(ramp_busy) == 3'h0 &&
        $past(buck_c_voltage_mv) != 12'h0 |-> $stable(buck_a_voltage_mv) &&
        $stable(buck_b_voltage_mv) && $stable(buck_c_voltage_mv))
        else $error("output moved while no ramp was busy");
    power_up_a: assert property ($fell(rst) |-> buck_on == 3'h0 ##[3:8] buck_on == 3'h7)
        else $error("regulators not on after reset release");

    // ****************************************
    // Register port
    // ****************************************
    unmapped_zero_a: assert property (reg_rd && reg_addr > 8'h40 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_width_a: assert property (reg_rd && reg_addr >= 8'h20 && reg_addr <= 8'h22
        |=> reg_rdata[7:5] == 3'h0) else $error("buck a code upper bits set");
    b_width_a: assert property (reg_rd && reg_addr >= 8'h35 && reg_addr <= 8'h37
        |=> reg_rdata[7:3] == 5'h0) else $error("buck b code upper bits set");
    c_width_a: assert property (reg_rd && reg_addr >= 8'h3c && reg_addr <= 8'h3e
        |=> reg_rdata[7:4] == 4'h0) else $error("buck c code upper bits set");
    config_alias_a: assert property ((reg_wr && reg_addr == 8'h24) ##2
        (reg_rd && reg_addr == 8'h32) |=> reg_rdata == $past(reg_wdata, 3))
        else $error("config alias read differs from write");
    standby_keep_a: assert property ((reg_wr && reg_addr == 8'h21) ##2
        (reg_rd && reg_addr == 8'h21) |=> reg_rdata == ($past(reg_wdata, 3) & 8'h1f))
        else $error("standby code read back wrong");
endmodule // buck_bank_props

bind buck_setpoint_register_bank buck_bank_props buck_bank_props_i
(
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .buck_a_fuse_voltage(buck_a_fuse_voltage), .buck_b_high_range_fuse(buck_b_high_range_fuse),
    .standby_req(standby_req), .sleep_req(sleep_req),
    .buck_a_voltage_mv(buck_a_voltage_mv), .buck_b_voltage_mv(buck_b_voltage_mv),
    .buck_c_voltage_mv(buck_c_voltage_mv), .buck_on(buck_on), .ramp_busy(ramp_busy)
);

// ==== tb/buck_host_model.sv ====
// Host model that reaches the register port one byte at a time
module buck_host_model
(
    // Clock
    input  wire logic       clk_sys,
    // Register port
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end

    // Request held from one edge to the next, where it is taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Data is registered at the taking edge, so it is picked up half a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
endmodule // buck_host_model

// ==== tb/buck_setpoint_register_bank_tb.sv ====
// Self-checking testbench for the buck set-point register bank
module buck_setpoint_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  buck_a_fuse_voltage = 5'h1e;
    logic        buck_b_high_range_fuse = 1'b1;
    logic        standby_req = 1'b0;
    logic        sleep_req = 1'b0;
    wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire         reg_wr, reg_rd;
    wire  [11:0] buck_a_voltage_mv, buck_b_voltage_mv, buck_c_voltage_mv;
    wire  [2:0]  buck_on, ramp_busy;
    int          bad_count = 0;
    int          check_count = 0;
    logic [7:0]  ra [16] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h32, 8'h35, 8'h36,
                             8'h37, 8'h38, 8'h39, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40};
    logic [7:0]  rv [16] = '{8'h1e, 8'h1e, 8'h1e, 8'h08, 8'h04, 8'h04, 8'h00, 8'h00,
                             8'h00, 8'h08, 8'h14, 8'h00, 8'h00, 8'h00, 8'h08, 8'h24};
    logic [7:0]  wm [16] = '{8'h1f, 8'h1f, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h07, 8'h07,
                             8'h07, 8'h00, 8'h00, 8'h0f, 8'h0f, 8'h0f, 8'h00, 8'h00};

    always #50 clk_sys = ~clk_sys;

    buck_setpoint_register_bank buck_setpoint_register_bank_i
    (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .buck_a_fuse_voltage(buck_a_fuse_voltage),
        .buck_b_high_range_fuse(buck_b_high_range_fuse),
        .standby_req(standby_req), .sleep_req(sleep_req),
        .buck_a_voltage_mv(buck_a_voltage_mv), .buck_b_voltage_mv(buck_b_voltage_mv),
        .buck_c_voltage_mv(buck_c_voltage_mv), .buck_on(buck_on), .ramp_busy(ramp_busy)
    );

    buck_host_model buck_host_model_i
    (
        .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    // ****************************************
    // Expected voltages and helpers
    // ****************************************
    function automatic logic [11:0] a_mv(input logic [4:0] c);
        return (c < 5'd30) ? 12'd700 + 12'd25 * c : ((c == 5'h1e) ? 12'd1800 : 12'd3300);
    endfunction

    function automatic logic [11:0] b_mv(input logic [2:0] c, input logic hi);
        logic [11:0] t [8] = '{12'd2500, 12'd2800, 12'd2850, 12'd3000,
                               12'd3100, 12'd3150, 12'd3200, 12'd3300};
        return hi ? t[c] : 12'd1500 + 12'd50 * c;
    endfunction

    function automatic logic [11:0] c_mv(input logic [3:0] c);
        return 12'd900 + 12'd50 * c;
    endfunction

    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        buck_host_model_i.rd(a, d);
        check($sformatf("reg %h", a), {4'h0, d}, {4'h0, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        buck_host_model_i.wr(a, d);
    endtask

    // Bounded wait: a stuck ramp shows up in the following voltage compare
    task automatic settle();
        int n;
        n = 0;
        repeat (4) @(negedge clk_sys);
        while (ramp_busy !== 3'h0 && n < 4000)
        begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    task automatic expect_v(input logic [11:0] a, input logic [11:0] b, input logic [11:0] c);
        check("buck_a_mv", buck_a_voltage_mv, a);
        check("buck_b_mv", buck_b_voltage_mv, b);
        check("buck_c_mv", buck_c_voltage_mv, c);
    endtask

    // Counts cycles between two successive steps of buck C
    task automatic measure(input int exp);
        logic [11:0] v;
        int n;
        for (int k = 0; k < 2; k++)
        begin
            v = buck_c_voltage_mv;
            n = 0;
            while (buck_c_voltage_mv === v && n < 200)
            begin
                @(negedge clk_sys);
                n++;
            end
        end
        check("step_cycles", n[11:0], exp[11:0]);
    endtask

    task automatic reset_dut();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        reset_dut();
        for (int i = 0; i < 16; i++)
            rdchk(ra[i], rv[i]);
        expect_v(a_mv(5'h1e), b_mv(3'h0, 1'b1), c_mv(4'h0));
        for (int i = 0; i < 16; i++)
        begin
            if (wm[i] != 8'h00)
            begin
                wr(ra[i], 8'hff);
                rdchk(ra[i], wm[i]);
            end
        end
        wr(8'h25, 8'h5a);
        rdchk(8'h25, 8'h00);
        rdchk(8'h41, 8'h00);
        wr(8'h24, 8'h47);
        rdchk(8'h32, 8'h47);
        wr(8'h32, 8'h04);
        rdchk(8'h24, 8'h04);
        wr(8'h23, 8'hff);
        rdchk(8'h23, 8'h2f);
        wr(8'h23, 8'h08);
        settle();
        expect_v(12'd3300, 12'd3300, 12'd1650);
        for (int i = 0; i < 16; i++)
        begin
            wr(8'h20, 8'(16 + i));
            wr(8'h35, 8'(i % 8));
            wr(8'h3c, 8'(i));
            settle();
            expect_v(a_mv(5'(16 + i)), b_mv(3'(i), 1'b1), c_mv(4'(i)));
        end
        // Range fuse moved without a reset must not change the table
        @(posedge clk_sys);
        buck_b_high_range_fuse <= 1'b0;
        wr(8'h35, 8'h03);
        settle();
        check("buck_b_mv", buck_b_voltage_mv, b_mv(3'h3, 1'b1));
        wr(8'h21, 8'h10);
        rdchk(8'h21, 8'h10);
        wr(8'h36, 8'h01);
        wr(8'h3d, 8'h04);
        standby_req <= 1'b1;
        settle();
        expect_v(12'd1100, 12'd2800, 12'd1100);
        wr(8'h3f, 8'h28);
        wr(8'h3e, 8'h0f);
        sleep_req <= 1'b1;
        settle();
        check("buck_c_mv", buck_c_voltage_mv, 12'd1650);
        check("buck_on", {9'h0, buck_on}, 12'h004);
        @(posedge clk_sys);
        standby_req <= 1'b0;
        sleep_req <= 1'b0;
        settle();
        expect_v(12'd3300, 12'd3000, 12'd1650);
        check("buck_on", {9'h0, buck_on}, 12'h007);
        wr(8'h40, 8'h64);
        wr(8'h3c, 8'h0d);
        measure(40);
        settle();
        wr(8'h40, 8'h24);
        wr(8'h3c, 8'h0f);
        measure(20);
        @(posedge clk_sys);
        buck_a_fuse_voltage <= 5'h00;
        reset_dut();
        rdchk(8'h21, 8'h00);
        expect_v(12'd700, 12'd1500, 12'd900);
        for (int i = 1; i < 8; i++)
        begin
            wr(8'h35, 8'(i));
            settle();
            check("buck_b_mv", buck_b_voltage_mv, b_mv(3'(i), 1'b0));
        end
        print_verdict();
    end

    initial
    begin
        #5000000;
        bad_count++;
        print_verdict();
    end
endmodule // buck_setpoint_register_bank_tb
